// ==== msvb_pkg.sv ====
// Purpose: Shared constants for the extension bus slave to VMEbus bridge
// Assumes: 50 MHz clock, synchronous active-high reset
// Notes:   Rule overview below; timeout counts derive from the clock rate
//
// Overview of operation
// RQ1 - Remote byte, halfword and word reads and writes become A16/A24/A32 VMEbus cycles.
// RQ2 - Configuration space registers take only byte or halfword accesses.
// RQ3 - Every address and modifier is checked against four mapping windows.
// RQ4 - Only listed A24, A32, A16 and transparent acknowledge modifiers are answered.
// RQ5 - A window hit first wins the VMEbus, then runs the converted cycle.
// RQ6 - Size line and low two bits map onto data strobes, A01 and LWORD.
// RQ7 - Cycle ends after DTACK or BERR is relayed and both strobes are released.
// RQ8 - An address with bad parity never requests the VMEbus.
// RQ9 - Write data with bad parity is not forwarded; BERR is returned instead.
// RQ10 - Read data goes back with generated parity.
// RQ11 - Strobe held across transfers with block modifier gives a VMEbus block cycle.
// RQ12 - A VMEbus block is ended and restarted after every 256 bytes.
// RQ13 - Held strobe, non-block modifier, select bit 0 gives read-modify-write.
// RQ14 - Held strobe, non-block modifier, select bit 1 gives separate single cycles.
// RQ15 - Counters load on address strobe and advance on each data strobe release.
// RQ16 - Counter step equals transfer width in bytes.
// RQ17 - Running count is decoded each transfer so a block may enter a window.
// RQ18 - Shared address/data lines are demultiplexed and their direction controlled.
// RQ19 - As system controller the unit runs the system timeout logic.
// RQ20 - Masters upstream of the system controller are never granted and must not master.
// RQ21 - Timeout starts on data strobe, stops on DTACK or BERR, drives BERR on expiry.
// RQ22 - After reset the system timeout is short, in the microsecond range.
// RQ23 - Long timeout bit set by software stretches the timeout to milliseconds.
// RQ24 - Long timeout and select bits take defined values from reset.
package msvb_pkg;
  localparam int unsigned NUM_WIN          = 4;
  localparam int unsigned CLK_MHZ          = 50;
  localparam int unsigned SYS_TO_SHORT_US  = 200;
  localparam int unsigned SYS_TO_LONG_MS   = 200;
  localparam int unsigned SYS_TO_SHORT_CYC = SYS_TO_SHORT_US * CLK_MHZ;
  localparam int unsigned SYS_TO_LONG_CYC  = SYS_TO_LONG_MS * 1000 * CLK_MHZ;
  localparam int unsigned TO_CNT_W         = 24;
  localparam logic [8:0]  VME_BLOCK_BYTES  = 9'h100;
  localparam logic [8:0]  STEP_BYTE        = 9'h001;
  localparam logic [8:0]  STEP_HALF        = 9'h002;
  localparam logic [8:0]  STEP_LONG        = 9'h004;
  localparam logic [15:0] CFG_SPAN_MASK    = 16'hffc0;
  localparam logic [1:0]  AM_SP_A24        = 2'h3;
  localparam logic [1:0]  AM_SP_A16        = 2'h2;
  localparam logic [1:0]  AM_SP_A32        = 2'h0;
  localparam logic [2:0]  AM_BLK_SUP       = 3'h7;
  localparam logic [2:0]  AM_PRG_SUP       = 3'h6;
  localparam logic [2:0]  AM_DAT_SUP       = 3'h5;
  localparam logic [2:0]  AM_BLK_NP        = 3'h3;
  localparam logic [2:0]  AM_PRG_NP        = 3'h2;
  localparam logic [2:0]  AM_DAT_NP        = 3'h1;
  localparam logic        RMW_SEL_RST      = 1'b0;
  localparam logic        LONG_TO_RST      = 1'b0;

  // Level of the active-low parity pin for a data word
  function automatic logic parPin(input logic [31:0] d);
    return ^d;
  endfunction
endpackage

// ==== msvb_to_if.sv ====
`timescale 1ns/10ps
// Purpose: Carrier between bridge core and system timeout
// Assumes: Single clock domain
// Notes:   ctl side is the bridge, tmr side the timer
interface msvb_to_if;
  logic enable;
  logic longMode;
  logic dsActive;
  logic ackSeen;
  logic expired;
  modport ctl (output enable, output longMode, output dsActive, output ackSeen, input expired);
  modport tmr (input enable, input longMode, input dsActive, input ackSeen, output expired);
endinterface

// ==== msvb_sys_timeout.sv ====
`timescale 1ns/10ps
// Purpose: System controller bus timeout
// Assumes: Strobe and acknowledge levels already synchronous
// Notes:   Expiry holds until the data strobe is released
module msvb_sys_timeout #(
  parameter int unsigned SHORT_TO_CYC = msvb_pkg::SYS_TO_SHORT_CYC,
  parameter int unsigned LONG_TO_CYC  = msvb_pkg::SYS_TO_LONG_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  msvb_to_if.tmr    to
);
  logic [msvb_pkg::TO_CNT_W-1:0] cnt;
  logic                          fired;
  wire  logic [msvb_pkg::TO_CNT_W-1:0] limit;
  wire  logic                          running;

  assign limit   = to.longMode ? msvb_pkg::TO_CNT_W'(LONG_TO_CYC - 1)
                               : msvb_pkg::TO_CNT_W'(SHORT_TO_CYC - 1); // RQ22 RQ23
  assign running = to.enable && to.dsActive && !to.ackSeen && !fired; // RQ19 RQ21
  assign to.expired = fired;

  always_ff @(posedge clk)
  begin
    if (rst || !running)
      cnt <= '0;
    else
      cnt <= cnt + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst || !to.dsActive)
      fired <= 1'b0;
    else if (running && cnt == limit)
      fired <= 1'b1; // RQ21
  end
endmodule

// ==== msvb_bridge.sv ====
`timescale 1ns/10ps
// Purpose: Extension bus slave cycles into VMEbus cycles
// Assumes: All pins synchronous to clk; active-low pins named with N
// Notes:   Open-drain outputs pull low while their enable is high
module msvb_bridge #(
  parameter int unsigned NUM_WIN      = msvb_pkg::NUM_WIN,
  parameter int unsigned SHORT_TO_CYC = msvb_pkg::SYS_TO_SHORT_CYC,
  parameter int unsigned LONG_TO_CYC  = msvb_pkg::SYS_TO_LONG_CYC
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      sysCtlr,
  input  wire logic                      rmwSelectBit,
  input  wire logic                      longSysctlTimeoutBit,
  input  wire logic [NUM_WIN-1:0]        winEnable,
  input  wire logic [NUM_WIN-1:0][31:0]  winBase,
  input  wire logic [NUM_WIN-1:0][31:0]  winMask,
  input  wire logic [15:0]               cfgBase,
  input  wire logic                      mxAsN,
  input  wire logic                      mxDsN,
  input  wire logic                      mxWrN,
  input  wire logic                      mxSizeN,
  input  wire logic [4:0]                mxAm,
  input  wire logic [31:0]               mxAdIn,
  output logic      [31:0]               mxAdOut,
  output logic                           mxAdOe,
  input  wire logic                      mxParNIn,
  output logic                           mxParNOut,
  output logic                           mxParNOe,
  input  wire logic                      mxDtackNIn,
  output logic                           mxDtackNOut,
  output logic                           mxDtackNOe,
  input  wire logic                      mxBerrNIn,
  output logic                           mxBerrNOut,
  output logic                           mxBerrNOe,
  output logic                           vmeBreq,
  input  wire logic                      vmeBgrant,
  output logic                           vmeBbsy,
  output logic      [31:1]               vmeAddr,
  output logic      [5:0]                vmeAm,
  output logic                           vmeAsN,
  output logic                           vmeDs1N,
  output logic                           vmeDs0N,
  output logic                           vmeLwordN,
  output logic                           vmeWriteN,
  output logic      [31:0]               vmeDataOut,
  output logic                           vmeDataOe,
  input  wire logic [31:0]               vmeDataIn,
  input  wire logic                      vmeDtackN,
  input  wire logic                      vmeBerrN,
  output logic                           cfgReq,
  output logic                           cfgWrite,
  output logic      [5:0]                cfgAddr,
  output logic      [15:0]               cfgWdata,
  input  wire logic [15:0]               cfgRdata,
  input  wire logic                      cfgAck
);
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ARB, ST_VDATA, ST_CFG, ST_RESP, ST_SKIP} msvb_state_t;

  msvb_state_t  state;
  logic         asPrev;
  logic         dsPrev;
  logic [31:0]  addrCnt;
  logic [4:0]   amReg;
  logic         addrParOk;
  logic [8:0]   blkBytes;
  logic         rmwSel;
  logic         longTo;
  logic         isWrite;
  logic [8:0]   curStep;
  logic         respBerr;
  logic         vmeDsOn;
  logic         vmeLong;
  logic         vmeHalf;

  msvb_to_if to ();

  // Strobe edges
  wire logic asFall = asPrev && !mxAsN;
  wire logic dsFall = dsPrev && !mxDsN;
  wire logic dsRise = !dsPrev && mxDsN;

  // Transfer size from size line and low bits
  wire logic       sizeWide = !mxSizeN;
  wire logic       xferLong = sizeWide && (addrCnt[1:0] == 2'h3);
  wire logic       xferHalf = sizeWide && !xferLong;
  wire logic [8:0] xferStep = xferLong ? msvb_pkg::STEP_LONG
                            : xferHalf ? msvb_pkg::STEP_HALF : msvb_pkg::STEP_BYTE; // RQ16

  // Modifier decode
  wire logic [1:0] amSpace = amReg[4:3];
  wire logic [2:0] amLow   = amReg[2:0];
  wire logic wideLow = (amLow == msvb_pkg::AM_BLK_SUP) || (amLow == msvb_pkg::AM_PRG_SUP)
                    || (amLow == msvb_pkg::AM_DAT_SUP) || (amLow == msvb_pkg::AM_BLK_NP)
                    || (amLow == msvb_pkg::AM_PRG_NP) || (amLow == msvb_pkg::AM_DAT_NP);
  wire logic a16Low  = (amLow == msvb_pkg::AM_DAT_SUP) || (amLow == msvb_pkg::AM_PRG_NP)
                    || (amLow == msvb_pkg::AM_DAT_NP);
  wire logic isA16   = amSpace == msvb_pkg::AM_SP_A16;
  wire logic amOk    = ((amSpace == msvb_pkg::AM_SP_A24 || amSpace == msvb_pkg::AM_SP_A32) && wideLow)
                    || (isA16 && a16Low); // RQ4
  wire logic blockAm = !isA16 && (amLow == msvb_pkg::AM_BLK_SUP || amLow == msvb_pkg::AM_BLK_NP);

  // Window decode on the running count
  wire logic [NUM_WIN-1:0] winHit;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_WIN; gi++)
    begin : g_win
      assign winHit[gi] = winEnable[gi] && (((addrCnt ^ winBase[gi]) & winMask[gi]) == 32'h0); // RQ3 RQ17
    end
  endgenerate

  wire logic cfgHit   = isA16 && (((addrCnt[15:0] ^ cfgBase) & msvb_pkg::CFG_SPAN_MASK) == 16'h0);
  wire logic ourCycle = amOk && addrParOk && (cfgHit || (|winHit)); // RQ3 RQ8
  wire logic dataParOk = mxParNIn == msvb_pkg::parPin(mxAdIn);
  wire logic vmeAcked = !vmeDtackN || !vmeBerrN;
  wire logic vmeIdle  = vmeDtackN && vmeBerrN;

  // Keep the VMEbus address strobe between transfers?
  wire logic [8:0] blkNext = blkBytes + curStep;
  wire logic keepAs = blockAm ? (blkNext < msvb_pkg::VME_BLOCK_BYTES) : !rmwSel; // RQ11 RQ12 RQ13 RQ14

  // Timeout hookup
  assign to.enable   = sysCtlr; // RQ19 RQ20
  assign to.longMode = longTo;
  assign to.dsActive = !mxDsN;
  assign to.ackSeen  = !mxDtackNIn || !mxBerrNIn;

  msvb_sys_timeout #(
    .SHORT_TO_CYC (SHORT_TO_CYC),
    .LONG_TO_CYC  (LONG_TO_CYC)
  ) u_timeout (
    .clk (clk),
    .rst (rst),
    .to  (to)
  );

  // Open-drain lines only ever pull low
  assign mxDtackNOut = 1'b0;
  assign mxBerrNOut  = 1'b0;
  assign mxBerrNOe   = (state == ST_RESP && respBerr) || to.expired; // RQ9 RQ21
  assign mxDtackNOe  = state == ST_RESP && !respBerr; // RQ7
  assign mxParNOe    = mxAdOe; // RQ10
  assign vmeDataOe   = vmeDsOn && isWrite;
  assign vmeDs1N     = !(vmeDsOn && (vmeLong || vmeHalf || !addrCnt[0])); // RQ6
  assign vmeDs0N     = !(vmeDsOn && (vmeLong || vmeHalf || addrCnt[0])); // RQ6
  assign vmeLwordN   = !vmeLong; // RQ6
  assign vmeAddr     = {addrCnt[31:2], addrCnt[1] && !vmeLong}; // RQ1 RQ6
  assign vmeAm       = {amReg[4], amReg[3], 1'b1, amReg[2:0]};
  assign vmeWriteN   = !isWrite;

  // Control bits with defined reset values
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rmwSel <= msvb_pkg::RMW_SEL_RST;
      longTo <= msvb_pkg::LONG_TO_RST;
    end
    else
    begin
      rmwSel <= rmwSelectBit; // RQ24
      longTo <= longSysctlTimeoutBit; // RQ24
    end
  end

  // Strobe history
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      asPrev <= 1'b1;
      dsPrev <= 1'b1;
    end
    else
    begin
      asPrev <= mxAsN;
      dsPrev <= mxDsN;
    end
  end

  // Address counter and latched address phase
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      addrCnt   <= 32'h0;
      amReg     <= 5'h0;
      addrParOk <= 1'b0;
    end
    else if (asFall)
    begin
      addrCnt   <= mxAdIn; // RQ15 RQ18
      amReg     <= mxAm;
      addrParOk <= mxParNIn == msvb_pkg::parPin(mxAdIn); // RQ8
    end
    else if (dsRise && !mxAsN)
      addrCnt <= addrCnt + {23'h0, curStep}; // RQ15 RQ16
  end

  // Slave cycle sequencer
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state      <= ST_IDLE;
      vmeBreq    <= 1'b0;
      vmeBbsy    <= 1'b0;
      vmeAsN     <= 1'b1;
      vmeDsOn    <= 1'b0;
      vmeLong    <= 1'b0;
      vmeHalf    <= 1'b0;
      vmeDataOut <= 32'h0;
      isWrite    <= 1'b0;
      curStep    <= msvb_pkg::STEP_BYTE;
      respBerr   <= 1'b0;
      blkBytes   <= 9'h0;
      mxAdOut    <= 32'h0;
      mxAdOe     <= 1'b0;
      mxParNOut  <= 1'b0;
      cfgReq     <= 1'b0;
      cfgWrite   <= 1'b0;
      cfgAddr    <= 6'h0;
      cfgWdata   <= 16'h0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (asFall)
            state <= ST_ADDR;
        end
        ST_ADDR:
        begin
          if (mxAsN)
          begin
            state    <= ST_IDLE;
            vmeBreq  <= 1'b0;
            vmeBbsy  <= 1'b0;
            vmeAsN   <= 1'b1;
            blkBytes <= 9'h0;
          end
          else if (dsFall)
          begin
            isWrite    <= !mxWrN;
            curStep    <= xferStep;
            vmeLong    <= xferLong;
            vmeHalf    <= xferHalf;
            vmeDataOut <= mxAdIn; // RQ18
            cfgWrite   <= !mxWrN;
            cfgAddr    <= addrCnt[5:0];
            cfgWdata   <= mxAdIn[15:0];
            if (!ourCycle)
              state <= ST_SKIP; // RQ4 RQ8
            else if (!mxWrN && !dataParOk)
            begin
              state    <= ST_RESP; // RQ9
              respBerr <= 1'b1;
            end
            else if (cfgHit)
            begin
              if (xferLong)
              begin
                state    <= ST_RESP; // RQ2
                respBerr <= 1'b1;
              end
              else
              begin
                state  <= ST_CFG; // RQ2
                cfgReq <= 1'b1;
              end
            end
            else if (vmeBbsy)
              state <= ST_VDATA;
            else
            begin
              state   <= ST_ARB; // RQ5
              vmeBreq <= 1'b1;
            end
          end
        end
        ST_ARB:
        begin
          if (mxDsN)
          begin
            state   <= ST_ADDR;
            vmeBreq <= 1'b0;
          end
          else if (vmeBgrant)
          begin
            state   <= ST_VDATA; // RQ5
            vmeBreq <= 1'b0;
            vmeBbsy <= 1'b1;
          end
        end
        ST_VDATA:
        begin
          if (mxDsN)
          begin
            state   <= ST_ADDR;
            vmeDsOn <= 1'b0;
            vmeAsN  <= 1'b1;
          end
          else if (vmeDsOn && vmeAcked)
          begin
            state     <= ST_RESP; // RQ7
            vmeDsOn   <= 1'b0;
            respBerr  <= !vmeBerrN;
            mxAdOut   <= vmeDataIn; // RQ18
            mxParNOut <= msvb_pkg::parPin(vmeDataIn); // RQ10
            mxAdOe    <= !isWrite && vmeBerrN; // RQ10 RQ18
          end
          else if (!vmeDsOn && vmeIdle)
          begin
            vmeAsN  <= 1'b0; // RQ1
            vmeDsOn <= 1'b1;
          end
        end
        ST_CFG:
        begin
          if (mxDsN)
          begin
            state  <= ST_ADDR;
            cfgReq <= 1'b0;
          end
          else if (cfgAck)
          begin
            state     <= ST_RESP;
            cfgReq    <= 1'b0;
            respBerr  <= 1'b0;
            mxAdOut   <= {16'h0, cfgRdata};
            mxParNOut <= msvb_pkg::parPin({16'h0, cfgRdata}); // RQ10
            mxAdOe    <= !isWrite;
          end
        end
        ST_RESP:
        begin
          if (dsRise)
          begin
            state    <= ST_ADDR; // RQ7
            respBerr <= 1'b0;
            mxAdOe   <= 1'b0;
            if (vmeBbsy && !keepAs)
            begin
              vmeAsN   <= 1'b1; // RQ12 RQ14
              blkBytes <= 9'h0;
            end
            else if (vmeBbsy)
              blkBytes <= blkNext; // RQ12
          end
        end
        ST_SKIP:
        begin
          if (dsRise)
            state <= ST_ADDR; // RQ17
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end
endmodule

// ==== msvb_bridge_chk.sv ====
`timescale 1ns/10ps
// Purpose: Port-level checks of the bridge
// Assumes: Bound into msvb_bridge
// Notes:   Timeout limits allow eight cycles of latency
module msvb_bridge_chk #(
  parameter int unsigned SHORT_TO_CYC = 20,
  parameter int unsigned LONG_TO_CYC  = 50
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        sysCtlr,
  input wire logic        longSysctlTimeoutBit,
  input wire logic        mxDsN,
  input wire logic        mxDtackNIn,
  input wire logic        mxBerrNIn,
  input wire logic        mxDtackNOe,
  input wire logic        mxBerrNOe,
  input wire logic        mxAdOe,
  input wire logic [31:0] mxAdOut,
  input wire logic        mxParNOut,
  input wire logic        vmeAsN,
  input wire logic        vmeBreq,
  input wire logic        vmeBbsy,
  input wire logic        vmeBgrant,
  input wire logic        vmeLwordN,
  input wire logic [31:1] vmeAddr,
  input wire logic        vmeDs0N,
  input wire logic        vmeDs1N,
  input wire logic        vmeDataOe,
  input wire logic        vmeWriteN,
  input wire logic        cfgReq
);
  logic [15:0] toCnt;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Cycles a data strobe waits unanswered
  always_ff @(posedge clk)
  begin
    if (rst || mxDsN || !mxDtackNIn || !mxBerrNIn || !sysCtlr)
      toCnt <= 16'h0;
    else if (toCnt != 16'hffff)
      toCnt <= toCnt + 16'h1;
  end

  a_rst_idle: assert property (disable iff (1'b0) rst |=> vmeAsN && !vmeBreq && !vmeBbsy
    && !mxDtackNOe && !mxBerrNOe && !mxAdOe && !cfgReq) else $error("outputs not idle after reset");
  a_ack_stands: assert property (mxDtackNOe && !mxDsN |=> mxDtackNOe)
    else $error("acknowledge dropped while strobe low");
  a_ack_drops: assert property (mxDsN |=> !mxDtackNOe && !mxBerrNOe)
    else $error("answer held after strobe release");
  a_par_read: assert property (mxAdOe |-> mxParNOut == ^mxAdOut)
    else $error("read parity wrong");
  a_bus_owned: assert property (!vmeAsN |-> vmeBbsy)
    else $error("VME cycle without bus ownership");
  a_busy_granted: assert property ($rose(vmeBbsy) |-> $past(vmeBgrant))
    else $error("bus taken without grant");
  a_long_lanes: assert property (!vmeLwordN |-> !vmeAddr[1] && vmeDs0N == vmeDs1N)
    else $error("long transfer lanes wrong");
  a_write_drive: assert property (vmeDataOe |-> !vmeWriteN && !vmeAsN)
    else $error("data driven outside a write");
  a_short_limit: assert property (sysCtlr && !longSysctlTimeoutBit |-> toCnt <= SHORT_TO_CYC + 8)
    else $error("short timeout overran");
  a_long_limit: assert property (toCnt <= LONG_TO_CYC + 8)
    else $error("long timeout overran");
endmodule

bind msvb_bridge msvb_bridge_chk #(.SHORT_TO_CYC(SHORT_TO_CYC), .LONG_TO_CYC(LONG_TO_CYC)) chk_u (.*);

// ==== msvb_vme_model.sv ====
`timescale 1ns/10ps
// Purpose: VMEbus arbiter, slave and config responder
// Assumes: Strobes active low, sampled on clk
// Notes:   Read data is a pattern of the address
module msvb_vme_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic        mute,
  input  wire logic        vmeBreq,
  input  wire logic [31:1] vmeAddr,
  input  wire logic        vmeAsN,
  input  wire logic        vmeDs0N,
  input  wire logic        vmeDs1N,
  input  wire logic        vmeWriteN,
  input  wire logic [31:0] vmeDataOut,
  input  wire logic        cfgReq,
  input  wire logic        cfgWrite,
  input  wire logic [15:0] cfgWdata,
  output logic             vmeBgrant,
  output logic             vmeDtackN,
  output logic             vmeBerrN,
  output logic      [31:0] vmeDataIn,
  output logic             cfgAck,
  output logic      [15:0] cfgRdata,
  output logic      [31:0] lastWr
);
  logic [1:0] dly;
  wire        strobe = !vmeAsN && !(vmeDs0N && vmeDs1N);
  wire        berrHit = vmeAddr[29] && vmeAddr[15];

  initial
  begin
    {vmeDataIn, lastWr, cfgRdata, dly} = 82'h0;
  end

  always @(posedge clk)
  begin
    vmeBgrant <= #1 vmeBreq && !rst;
    cfgAck <= #1 cfgReq && !cfgAck && !rst;
    if (cfgReq && !cfgAck && cfgWrite)
      lastWr <= #1 {16'h0, cfgWdata};
    cfgRdata <= #1 ~cfgRdata;
    if (rst || !strobe)
    begin
      dly <= #1 2'h0;
      vmeDtackN <= #1 1'b1;
      vmeBerrN <= #1 1'b1;
      vmeDataIn <= #1 ~vmeDataIn;
    end
    else if (mute || dly != (slow ? 2'h3 : 2'h0))
      dly <= #1 dly + 2'h1;
    else
    begin
      vmeDtackN <= #1 berrHit;
      vmeBerrN <= #1 !berrHit;
      vmeDataIn <= #1 {vmeAddr[31:2], 2'h0} ^ 32'h5a5a_5a5a;
      if (!vmeWriteN && vmeDtackN && !berrHit)
        lastWr <= #1 vmeDataOut;
    end
  end
endmodule

// ==== tb.sv ====
`timescale 1ns/10ps
// Purpose: Self-checking bench playing the remote master
// Assumes: Timeouts shortened to 20 and 50 cycles
// Notes:   Driver queues expected answers, monitor compares
module tb;
  localparam int          SHORT = 20;
  localparam int          LONG  = 50;
  localparam logic [31:0] K     = 32'h5a5a_5a5a;
  `define CHK(g, e) begin nTests++; if ((g) !== (e)) begin nErrors++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end

  logic        clk, rst, sysCtlr, rmwSelectBit, longSysctlTimeoutBit, mxAsN, mxDsN, mxWrN, mxSizeN;
  logic        mxAdOe, mxParNOut, mxParNOe, mxDtackNOut, mxDtackNOe, mxBerrNOut, mxBerrNOe, vmeBreq;
  logic        vmeBgrant, vmeBbsy, vmeAsN, vmeDs1N, vmeDs0N, vmeLwordN, vmeWriteN, vmeDataOe;
  logic        vmeDtackN, vmeBerrN, cfgReq, cfgWrite, cfgAck, tbPar, slow, mute, seen, seen2, vPrev, sawReq;
  logic [3:0]  winEnable;
  logic [4:0]  mxAm;
  logic [5:0]  vmeAm, cfgAddr;
  logic [15:0] cfgBase, cfgWdata, cfgRdata;
  logic [31:0] tbAd, mxAdOut, vmeDataOut, vmeDataIn, lastWr, lastW, adr;
  logic [31:1] vmeAddr;
  logic [3:0][31:0] winBase, winMask;
  logic [34:0] q[$];
  logic [4:0]  amTab[17] = '{5'h1f, 5'h1e, 5'h1d, 5'h1b, 5'h1a, 5'h19, 5'h15, 5'h12, 5'h11,
                             5'h07, 5'h06, 5'h05, 5'h03, 5'h02, 5'h01, 5'h00, 5'h17};
  int          szOff[7] = '{0, 1, 2, 3, 16, 18, 35};
  int          nErrors, nTests, rises;
  wire  [31:0] mxAdIn = mxAdOe ? mxAdOut : tbAd;
  wire         mxParNIn = mxParNOe ? mxParNOut : tbPar;
  wire         mxDtackNIn = !mxDtackNOe;
  wire         mxBerrNIn = !mxBerrNOe;

  msvb_bridge #(.SHORT_TO_CYC(SHORT), .LONG_TO_CYC(LONG)) dut_u (.*);
  msvb_vme_model vme_u (.*);

  task automatic testDone;
    if (nErrors == 0 && nTests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic aPh(input logic [31:0] a, input logic [4:0] am, input logic bad);
    tbAd = a;
    tbPar = ^a ^ bad;
    mxAm = am;
    mxAsN = 1'b0;
    adr = a;
    tick();
  endtask

  task automatic endA;
    mxAsN = 1'b1;
    tick(2);
  endtask

  // Kind 0 no answer, 1 acknowledge, 2 bus error
  task automatic dPh(input logic w, input int sz, input logic [31:0] d, input logic bad, input int kind,
                     output int cyc);
    logic [31:0] e;
    e = kind != 1 ? lastW : w ? d : {adr[31:2], 2'h0} ^ K;
    if (kind != 0)
      q.push_back({kind == 2, kind == 1, !w && kind == 1 && ^e, e});
    if (w && kind == 1)
      lastW = d;
    tbAd = w ? d : ~tbAd;
    tbPar = ^d ^ bad;
    mxWrN = !w;
    mxSizeN = sz == 0;
    mxDsN = 1'b0;
    cyc = 0;
    while (!(mxDtackNOe || mxBerrNOe) && cyc < 80)
    begin
      tick();
      cyc++;
    end
    if (kind != 0 && cyc == 80)
    begin
      nErrors++;
      testDone();
    end
    tick();
    mxDsN = 1'b1;
    tick(3);
    adr += 32'h1 << sz;
  endtask

  task automatic burst(input logic [31:0] a, input logic [4:0] am, input int sz, input int n, input int skip,
                       input int nr);
    int c;
    c = $urandom;
    slow = c[0];
    rises = 0;
    aPh(a, am, 1'b0);
    for (int i = 0; i < n; i++)
      dPh(i[0], sz, $urandom, 1'b0, i < skip ? 0 : 1, c);
    endA();
    `CHK(rises, nr)
  endtask

  task automatic toRun(input int lim);
    int c;
    aPh(32'h0010_0e03, 5'h05, 1'b0);
    dPh(1'b0, 2, 32'h0, 1'b0, 2, c);
    endA();
    `CHK(c >= lim && c <= lim + 6, 1'b1)
  endtask

  always @(posedge clk)
  begin
    if ((mxDtackNOe || mxBerrNOe) && seen && !seen2)
    begin
      if (q.size() == 0)
        `CHK(1'b1, 1'b0)
      else
        `CHK({mxBerrNOe, mxDtackNOe, mxAdOe && mxParNOut, mxAdOe ? mxAdOut : lastWr}, q.pop_front())
    end
    if (!vmeAsN)
      `CHK(vmeAm, {mxAm[4:3], 1'b1, mxAm[2:0]})
    seen <= mxDtackNOe || mxBerrNOe;
    seen2 <= seen;
    if (!mxAsN && vmeAsN && !vPrev)
      rises++;
    vPrev <= vmeAsN;
    if (vmeBreq)
      sawReq = 1'b1;
  end

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    int c;
    {rst, mxAsN, mxDsN, mxWrN, mxSizeN, tbPar} = 6'h3f;
    {sysCtlr, rmwSelectBit, longSysctlTimeoutBit, slow, mute, seen, seen2, vPrev, sawReq} = 9'h0;
    {mxAm, tbAd, lastW, adr} = 101'h0;
    winEnable = 4'h3;
    cfgBase = 16'hc000;
    winBase = {32'h0, 32'h3000_0000, 32'h2000_0000, 32'h0010_0000};
    winMask = {32'h0, 32'hffff_0000, 32'hffff_0000, 32'hfff0_0000};
    tick(20);
    rst = 1'b0;
    tick();
    void'($urandom(43));
    foreach (amTab[i])
      burst(32'h0010_0103, amTab[i], 2, 1, i > 14 ? 1 : 0, 0);
    for (int i = 0; i < 7; i++)
      burst(32'h0010_0200 + szOff[i] % 16, 5'h05, szOff[i] / 16, 2, 0, 0);
    burst(32'h2000_0003, 5'h01, 2, 2, 0, 0);
    burst(32'h3000_0003, 5'h01, 2, 1, 1, 0);
    aPh(32'h2000_8003, 5'h01, 1'b0);
    dPh(1'b1, 2, $urandom, 1'b0, 2, c);
    endA();
    sawReq = 1'b0;
    aPh(32'h0010_0303, 5'h05, 1'b1);
    dPh(1'b0, 2, 32'h0, 1'b0, 0, c);
    endA();
    `CHK(sawReq, 1'b0)
    aPh(32'h0010_0303, 5'h05, 1'b0);
    dPh(1'b1, 2, $urandom, 1'b1, 2, c);
    endA();
    aPh(32'h0000_c004, 5'h15, 1'b0);
    dPh(1'b1, 1, $urandom & 32'hffff, 1'b0, 1, c);
    endA();
    aPh(32'h0000_c007, 5'h11, 1'b0);
    dPh(1'b1, 2, $urandom, 1'b0, 2, c);
    endA();
    burst(32'h0010_0403, 5'h07, 2, 65, 0, 1);
    burst(32'h0010_0800, 5'h03, 1, 3, 0, 0);
    burst(32'h0010_0a01, 5'h1b, 0, 3, 0, 0);
    burst(32'h000f_fff7, 5'h07, 2, 5, 3, 0);
    rmwSelectBit = 1'b1;
    burst(32'h0010_0c03, 5'h05, 2, 3, 0, 3);
    burst(32'h0010_0d03, 5'h03, 2, 3, 0, 0);
    {sysCtlr, mute} = 2'h3;
    toRun(SHORT);
    longSysctlTimeoutBit = 1'b1;
    tick(2);
    toRun(LONG);
    testDone();
  end
endmodule
